// ---- hw/emif_timing_defs.vh ----
// Purpose: Constants for the external memory timing engine
// Assumes: 8-bit register port, one system clock
// Notes:   Offsets are register-port addresses
`ifndef EMIF_TIMING_DEFS_VH
`define EMIF_TIMING_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_TIMING_CTRL    8'h84
`define OFS_CONFIG         8'h85
`define OFS_PAGE           8'h86
`define OFS_STATUS         8'h87

// ****************************************
// Timing register fields
// ****************************************
`define TC_SETUP_HI        7
`define TC_SETUP_LO        6
`define TC_WIDTH_HI        5
`define TC_WIDTH_LO        2
`define TC_HOLD_HI         1
`define TC_HOLD_LO         0

// ****************************************
// Config register fields
// ****************************************
`define CF_MODE_HI         4
`define CF_MODE_LO         2
`define CF_ALE_HI          1
`define CF_ALE_LO          0

// ****************************************
// Reset values
// ****************************************
`define RST_TIMING_CTRL    8'hff
`define RST_CONFIG         8'h03
`define RST_PAGE           8'h00

// ****************************************
// Mode codes
// ****************************************
`define MODE_MUX_NOBANK_A  3'h1
`define MODE_MUX_BANK      3'h2
`define MODE_MUX_NOBANK_B  3'h3
`define MODE_NMX_NOBANK_A  3'h5
`define MODE_NMX_BANK      3'h6
`define MODE_NMX_NOBANK_B  3'h7

// ****************************************
// Fixed overhead of a move, in system clocks
// ****************************************
`define MOVE_OVERHEAD      4'h4
`define OVERHEAD_LEAD      2'h2

`endif

// ---- hw/phase_counter.v ----
// Purpose: Loadable down counter marking the end of one bus phase
// Assumes: Same clock as the timing engine
// Notes:   done stands while the count is zero
`timescale 1ns/100ps
`default_nettype none

module phase_counter #(
	parameter W = 4
) (
	// Clock and reset
	input  wire         mclk,
	input  wire         rst,
	// Control
	input  wire         load,
	input  wire [W-1:0] load_val,
	// Status
	output wire         done
);

	reg [W-1:0] cnt_r;

	always @(posedge mclk or posedge rst) begin
		if (rst)
			cnt_r <= {W{1'b0}};
		else if (load)
			cnt_r <= load_val;
		else if (cnt_r != {W{1'b0}})
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
	end

	// Kept free of load: the caller builds load from done, a loop otherwise
	assign done = (cnt_r == {W{1'b0}});

endmodule // phase_counter

`default_nettype wire

// ---- hw/emif_timing.v ----
// Purpose: Timing engine for off-chip data moves to a parallel memory
// Assumes: One 100 MHz system clock, async active-high reset
// Notes:   One move at a time; start is ignored while busy
//
// Function
// - Timing register: setup, width, hold fields
// - Setup 00 none, 01 one cycle
// - Setup interval zero to three cycles
// - Strobe low one to sixteen cycles
// - Hold interval zero to three cycles
// - Latch strobe high one to four cycles
// - Latch strobe low one to four cycles
// - Write data leads strobe rise 1-19
// - Write data held zero to three cycles
// - Codes 101,110,111 non-multiplexed 16-bit moves
// - Codes 001,010,011 multiplexed 16-bit moves
// - 101/111 8-bit non-mux, no bank byte
// - 001/011 8-bit mux, no bank byte
// - 110 8-bit non-mux, page drives upper
// - 010 8-bit mux, page drives upper
// - Move takes programmed cycles plus four
// - Low address on shared pins while latch high
// - No bank: upper pins undriven 8-bit
// - Reset leaves timing at maximum delays
`timescale 1ns/100ps
`default_nettype none
`include "emif_timing_defs.vh"

module emif_timing (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Move request from the core
	input  wire        move_start,
	input  wire        move_write,
	input  wire        move_wide,
	input  wire [15:0] move_addr,
	input  wire [7:0]  move_wdata,
	output wire        move_busy,
	output reg         move_done,
	output reg  [7:0]  move_rdata,
	// External bus
	output reg  [7:0]  addr_hi,
	output reg         addr_hi_oe,
	output reg  [7:0]  addr_lo,
	output reg         addr_lo_oe,
	output reg  [7:0]  data_out,
	output reg         data_oe,
	input  wire [7:0]  data_in,
	output reg         ale,
	output reg         rd_n,
	output reg         wr_n
);

	// ****************************************
	// States
	// ****************************************
	// Lead and tail carry the fixed overhead; every pin is released there
	localparam [7:0] ST_IDLE = 8'h01;
	localparam [7:0] ST_ALEH = 8'h02;
	localparam [7:0] ST_ALEL = 8'h04;
	localparam [7:0] ST_SET  = 8'h08;
	localparam [7:0] ST_STB  = 8'h10;
	localparam [7:0] ST_HOLD = 8'h20;
	localparam [7:0] ST_TAIL = 8'h40;
	localparam [7:0] ST_LEAD = 8'h80;

	reg  [7:0]  timing_r;
	reg  [7:0]  config_r;
	reg  [7:0]  page_r;
	reg  [7:0]  state_r;
	reg  [7:0]  state_nxt;
	reg         wr_move_r;
	reg         wide_r;
	reg  [15:0] addr_r;
	reg  [7:0]  wdata_r;
	// Pin data pass two flops; the capture flags trail them to match
	reg  [7:0]  rdata_s1_r;
	reg  [7:0]  rdata_s2_r;
	reg         rd_cap1_r;
	reg         rd_cap2_r;
	reg         load;
	reg  [3:0]  load_val;
	wire        done;
	wire [2:0]  mode;
	wire        mux;
	wire        bank;
	wire [1:0]  setup_sel;
	wire [3:0]  width_sel;
	wire [1:0]  hold_sel;
	wire [1:0]  ale_sel;

	// ****************************************
	// Field decode
	// ****************************************
	assign setup_sel = timing_r[`TC_SETUP_HI:`TC_SETUP_LO];
	assign width_sel = timing_r[`TC_WIDTH_HI:`TC_WIDTH_LO];
	assign hold_sel  = timing_r[`TC_HOLD_HI:`TC_HOLD_LO];
	// One latch code sets both the high and the low latch phases
	assign ale_sel   = config_r[`CF_ALE_HI:`CF_ALE_LO];
	assign mode      = config_r[`CF_MODE_HI:`CF_MODE_LO];
	// Mode bit 2 clear means shared address/data pins
	assign mux       = !mode[2];
	assign bank      = (mode == `MODE_MUX_BANK) || (mode == `MODE_NMX_BANK);

	// Count loaded for a phase of n cycles is n-1
	function [3:0] phase_len;
		input [3:0] cycles;
		begin
			phase_len = cycles - 4'h1;
		end
	endfunction

	// ****************************************
	// Register port
	// ****************************************
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			timing_r <= `RST_TIMING_CTRL;
			config_r <= `RST_CONFIG;
			page_r   <= `RST_PAGE;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_TIMING_CTRL: timing_r <= reg_wdata;
				// Config bits 7:5 are not implemented and read as zero
				`OFS_CONFIG:      config_r <= {3'h0, reg_wdata[4:0]};
				`OFS_PAGE:        page_r   <= reg_wdata;
				// Unmapped offsets are ignored
				default:          ;
			endcase
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`OFS_TIMING_CTRL: reg_rdata <= timing_r;
				`OFS_CONFIG:      reg_rdata <= config_r;
				`OFS_PAGE:        reg_rdata <= page_r;
				// Status bit 0 shows a move in progress
				`OFS_STATUS:      reg_rdata <= {7'h00, move_busy};
				default:          reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	// ****************************************
	// Phase sequencer
	// ****************************************
	phase_counter #(
		.W (4)
	) u_phase (
		.mclk     (mclk),
		.rst      (rst),
		.load     (load),
		.load_val (load_val),
		.done     (done)
	);

	// A start while busy is dropped; the core waits for move_done
	assign move_busy = (state_r != ST_IDLE);

	// A zero-length setup or hold phase is skipped entirely, so the
	// mode and the setup and hold fields decide which phases exist.
	always @* begin
		state_nxt = state_r;
		load      = 1'b0;
		load_val  = 4'h0;
		case (state_r)
			ST_IDLE: begin
				if (move_start) begin
					load = 1'b1;
					// Fixed overhead of four is split: two lead cycles here,
					// two tail cycles after hold
					load_val = phase_len({2'h0, `OVERHEAD_LEAD});
					state_nxt = ST_LEAD;
				end
			end
			ST_ALEH: begin
				if (done) begin
					load      = 1'b1;
					// Low phase of the latch strobe lasts as long as the high phase
					load_val  = {2'h0, ale_sel};
					state_nxt = ST_ALEL;
				end
			end
			ST_ALEL: begin
				if (done) begin
					load = 1'b1;
					if (setup_sel != 2'h0) begin
						load_val  = phase_len({2'h0, setup_sel});
						state_nxt = ST_SET;
					end else begin
						load_val  = width_sel;
						state_nxt = ST_STB;
					end
				end
			end
			ST_SET: begin
				if (done) begin
					load      = 1'b1;
					load_val  = width_sel;
					state_nxt = ST_STB;
				end
			end
			ST_STB: begin
				if (done) begin
					load = 1'b1;
					if (hold_sel != 2'h0) begin
						load_val  = phase_len({2'h0, hold_sel});
						state_nxt = ST_HOLD;
					end else begin
						// Tail always follows, so the overhead stays four
						load_val  = phase_len(`MOVE_OVERHEAD - {2'h0, `OVERHEAD_LEAD});
						state_nxt = ST_TAIL;
					end
				end
			end
			ST_HOLD: begin
				if (done) begin
					load      = 1'b1;
					load_val  = phase_len(`MOVE_OVERHEAD - {2'h0, `OVERHEAD_LEAD});
					state_nxt = ST_TAIL;
				end
			end
			ST_TAIL: begin
				// Trailing overhead with the bus released, then idle
				if (done)
					state_nxt = ST_IDLE;
			end
			ST_LEAD: begin
				// Lead-in overhead, then the latch phases when multiplexed, else setup or strobe
				if (done) begin
					load = 1'b1;
					if (mux) begin
						load_val  = {2'h0, ale_sel};
						state_nxt = ST_ALEH;
					end else if (setup_sel != 2'h0) begin
						load_val  = phase_len({2'h0, setup_sel});
						state_nxt = ST_SET;
					end else begin
						load_val  = width_sel;
						state_nxt = ST_STB;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// ****************************************
	// Move capture and sequencing
	// ****************************************
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r    <= ST_IDLE;
			wr_move_r  <= 1'b0;
			wide_r     <= 1'b0;
			addr_r     <= 16'h0000;
			wdata_r    <= 8'h00;
			move_done  <= 1'b0;
			move_rdata <= 8'h00;
			rdata_s1_r <= 8'h00;
			rdata_s2_r <= 8'h00;
			rd_cap1_r  <= 1'b0;
			rd_cap2_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			rdata_s1_r <= data_in;
			rdata_s2_r <= rdata_s1_r;
			move_done  <= 1'b0;
			// Move fields are frozen at the start; later core changes are harmless
			if (state_r == ST_IDLE && move_start) begin
				wr_move_r <= move_write;
				wide_r    <= move_wide;
				addr_r    <= move_addr;
				wdata_r   <= move_wdata;
			end
			// The value on the pins in the strobe's last cycle leaves the second
			// flop two cycles later, still no later than move_done
			rd_cap1_r  <= (state_r == ST_STB) && done && !wr_move_r;
			rd_cap2_r  <= rd_cap1_r;
			if (rd_cap2_r)
				move_rdata <= rdata_s2_r;
			if (state_r != ST_IDLE && state_nxt == ST_IDLE)
				move_done <= 1'b1;
		end
	end

	// ****************************************
	// Pin drive, registered
	// ****************************************
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_hi    <= 8'h00;
			addr_hi_oe <= 1'b0;
			addr_lo    <= 8'h00;
			addr_lo_oe <= 1'b0;
			data_out   <= 8'h00;
			data_oe    <= 1'b0;
			ale        <= 1'b0;
			rd_n       <= 1'b1;
			wr_n       <= 1'b1;
		end else begin
			ale  <= (state_nxt == ST_ALEH);
			rd_n <= !(state_nxt == ST_STB && !wr_move_r);
			wr_n <= !(state_nxt == ST_STB && wr_move_r);
			// Pins follow the next state so they change with the state register
			if (state_nxt == ST_IDLE || state_nxt == ST_LEAD ||
			    state_nxt == ST_TAIL) begin
				addr_hi_oe <= 1'b0;
				addr_lo_oe <= 1'b0;
				data_oe    <= 1'b0;
			end else begin
				// 8-bit moves drive the upper byte only with bank select
				addr_hi    <= wide_r ? addr_r[15:8] : page_r;
				addr_hi_oe <= wide_r || bank;
				if (mux) begin
					// Low byte only while latch strobe is high
					addr_lo_oe <= 1'b0;
					data_oe    <= (state_nxt == ST_ALEH) || (wr_move_r &&
					              state_nxt != ST_ALEL);
					data_out   <= (state_nxt == ST_ALEH) ? addr_r[7:0] : wdata_r;
				end else begin
					addr_lo    <= addr_r[7:0];
					addr_lo_oe <= 1'b1;
					data_oe    <= wr_move_r;
					data_out   <= wdata_r;
				end
			end
		end
	end

endmodule // emif_timing

`default_nettype wire

// ---- verification/emif_timing_properties.sv ----
// Purpose: Port-level checks of the memory timing engine
// Assumes: One clock, async active-high reset
// Notes:   Shadows timing and config writes to learn the widths
`timescale 1ns/100ps
`default_nettype none
`include "emif_timing_defs.vh"

module emif_timing_properties (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_rdata,
	// Move and pins
	input  wire logic       move_start,
	input  wire logic       move_busy,
	input  wire logic       move_done,
	input  wire logic       data_oe,
	input  wire logic       ale,
	input  wire logic       rd_n,
	input  wire logic       wr_n
);
	// ********
	// Shadow state
	// ********
	logic [7:0] tc_r;
	logic [1:0] ac_r;
	logic [4:0] lc_r;
	logic [2:0] ah_r;
	wire        stb = !(rd_n && wr_n);
	// Widths change only between moves, so the shadow is exact
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tc_r <= `RST_TIMING_CTRL;
			ac_r <= 2'h3;
			lc_r <= 5'h00;
			ah_r <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == `OFS_TIMING_CTRL)
				tc_r <= reg_wdata;
			if (reg_wr && reg_addr == `OFS_CONFIG)
				ac_r <= reg_wdata[1:0];
			lc_r <= stb ? lc_r + 5'h01 : 5'h00;
			ah_r <= ale ? ah_r + 3'h1 : 3'h0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ********
	// Assertions
	// ********
	a_strobe_excl: assert property (!(!rd_n && !wr_n))
		else $error("read and write strobes low together");
	a_strobe_width: assert property ($fell(stb) |-> lc_r == {1'b0, tc_r[5:2]} + 5'h01)
		else $error("strobe width differs from programmed value");
	a_ale_width: assert property ($fell(ale) |-> ah_r == {1'b0, ac_r} + 3'h1)
		else $error("latch strobe high time differs from programmed value");
	a_ale_quiet: assert property (ale |-> rd_n && wr_n)
		else $error("strobe low while latch strobe high");
	a_wr_data_on: assert property (!wr_n |-> data_oe)
		else $error("write strobe low without data driven");
	a_done_pulse: assert property (move_done |=> !move_done)
		else $error("move done longer than one cycle");
	a_start_busy: assert property (move_start && !move_busy |=> move_busy)
		else $error("accepted move not busy");
	a_move_bound: assert property ($rose(move_busy) |-> ##[5:36] $fell(move_busy))
		else $error("move length out of range");
	a_tc_readback: assert property (reg_rd && reg_addr == `OFS_TIMING_CTRL |=> reg_rdata == tc_r)
		else $error("timing register readback wrong");
	c_write: cover property ($fell(wr_n));
	c_read: cover property ($fell(rd_n));
	c_latch: cover property ($fell(ale));
endmodule // emif_timing_properties

bind emif_timing emif_timing_properties u_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.move_start(move_start), .move_busy(move_busy), .move_done(move_done),
	.data_oe(data_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

// ---- verification/sram_model.sv ----
// Purpose: Parallel static RAM with an external low-address latch
// Assumes: Strobes sampled on the system clock
// Notes:   Indexed by the low address byte only
`timescale 1ns/100ps
`default_nettype none

module sram_model (
	// Clock
	input  wire logic       mclk,
	// Pins
	input  wire logic [7:0] addr_lo,
	input  wire logic       addr_lo_oe,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output wire logic [7:0] data_in,
	input  wire logic       ale,
	input  wire logic       rd_n,
	input  wire logic       wr_n
);
	logic [7:0] mem [0:255];
	logic [7:0] lat_r;
	logic [7:0] last_r = 8'h00;
	wire  [7:0] a = addr_lo_oe ? addr_lo : lat_r;
	// Released bus shows the inverse of the last level, never a held value
	assign data_in = data_oe ? data_out : (!rd_n ? mem[a] : ~last_r);
	always @(posedge mclk) begin
		last_r <= data_in;
		if (ale)
			lat_r <= data_out;
		if (!wr_n)
			mem[a] <= data_in;
	end
endmodule // sram_model
`default_nettype wire

// ---- verification/ext_memory_bus_timing_tb_top.sv ----
// Purpose: Self-checking bench of the memory timing engine
// Assumes: Engine and RAM model on one 100 MHz clock
// Notes:   Pin activity is counted per move by a monitor
`timescale 1ns/100ps
`default_nettype none
`include "emif_timing_defs.vh"

module ext_memory_bus_timing_tb_top;
	logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, move_start = 0;
	logic        move_write = 0, move_wide = 0, move_busy, move_done, addr_hi_oe;
	logic        addr_lo_oe, data_oe, ale, rd_n, wr_n, hi_seen;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, move_wdata = 0, move_rdata;
	logic [7:0]  addr_hi, addr_lo, data_out, data_in, hi_val;
	logic [7:0]  bz_n, lo_n, ah_n, al_n, dpre_n, dpost_n;
	logic [15:0] move_addr = 0;
	int          errors = 0, checks = 0, cyc = 0;
	emif_timing dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .move_start(move_start),
		.move_write(move_write), .move_wide(move_wide), .move_addr(move_addr),
		.move_wdata(move_wdata), .move_busy(move_busy), .move_done(move_done),
		.move_rdata(move_rdata), .addr_hi(addr_hi), .addr_hi_oe(addr_hi_oe),
		.addr_lo(addr_lo), .addr_lo_oe(addr_lo_oe), .data_out(data_out), .data_oe(data_oe),
		.data_in(data_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
	sram_model ram (.mclk(mclk), .addr_lo(addr_lo), .addr_lo_oe(addr_lo_oe),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n));
	always #5 mclk = ~mclk;
	// ********
	// Pin monitor
	// ********
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			end_sim;
		end
	end
	always @(posedge mclk) begin
		if (move_busy) bz_n <= bz_n + 1;
		if (!rd_n || !wr_n) lo_n <= lo_n + 1;
		if (ale) ah_n <= ah_n + 1;
		if (move_busy && !ale && ah_n != 0 && lo_n == 0 && rd_n && wr_n) al_n <= al_n + 1;
		if (data_oe && lo_n != 0 && rd_n && wr_n) dpost_n <= dpost_n + 1;
		else if (data_oe) dpre_n <= dpre_n + 1;
		if (addr_hi_oe) begin
			hi_seen <= 1'b1;
			hi_val <= addr_hi;
		end
	end
	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic mv(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d);
		int i;
		@(negedge mclk);
		{bz_n, lo_n, ah_n, al_n, dpre_n, dpost_n, hi_val, hi_seen} = '0;
		@(posedge mclk);
		{move_start, move_write, move_wide, move_addr, move_wdata} <= {1'b1, w, wide, a, d};
		@(posedge mclk);
		move_start <= 1'b0;
		i = 0;
		do begin
			@(posedge mclk);
			#1 i++;
		end while (move_done !== 1'b1 && i < 100);
		chk({7'h00, move_done}, 8'h01);
		@(posedge mclk);
		#1;
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		rdc(`OFS_TIMING_CTRL, `RST_TIMING_CTRL);
		wr(`OFS_CONFIG, 8'h14);
		mv(1'b1, 1'b1, 16'h0055, 8'ha5);
		chk(bz_n, 8'd26);
		chk(lo_n, 8'd16);
		wr(`OFS_TIMING_CTRL, 8'h5a);
		wr(8'h80, 8'h33);
		rdc(`OFS_TIMING_CTRL, 8'h5a);
		rdc(8'h80, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_timing;
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_TIMING_CTRL, {i[1:0], i[3:0] * 4'd5, 2'd3 - i[1:0]});
			mv(1'b1, 1'b1, 16'(16'h4000 + i), 8'(8'h30 + i));
			chk(bz_n, 8'(8 + 5 * i));
			chk(lo_n, 8'(1 + 5 * i));
			chk(dpre_n, 8'(1 + 6 * i));
			chk(dpost_n, 8'(3 - i));
			chk({7'h00, hi_seen}, 8'h01);
		end
		$display("test timing done");
	endtask
	task automatic t_modes;
		logic [2:0] m [6] = '{3'd1, 3'd2, 3'd3, 3'd5, 3'd6, 3'd7};
		logic       bank;
		wr(`OFS_TIMING_CTRL, 8'h0c);
		wr(`OFS_PAGE, 8'h3c);
		for (int k = 0; k < 6; k++) begin
			bank = m[k][1:0] == 2'b10;
			wr(`OFS_CONFIG, {3'b000, m[k], 2'b00});
			mv(1'b1, 1'b0, 16'(16'h0010 + k), 8'(8'hc0 + k));
			chk(bz_n, m[k][2] ? 8'd8 : 8'd10);
			chk(ah_n, {7'h00, !m[k][2]});
			chk({7'h00, hi_seen}, {7'h00, bank});
			chk(hi_val, bank ? 8'h3c : 8'h00);
			mv(1'b0, 1'b1, 16'(16'h3c10 + k), 8'h00);
			chk(move_rdata, 8'(8'hc0 + k));
			chk(hi_val, 8'h3c);
		end
		$display("test modes done");
	endtask
	task automatic t_ale;
		wr(`OFS_TIMING_CTRL, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(`OFS_CONFIG, {6'h01, c[1:0]});
			mv(1'b1, 1'b1, 16'h0077, 8'h00);
			chk(ah_n, 8'(1 + c));
			chk(al_n, 8'(1 + c));
			chk(bz_n, 8'(7 + 2 * c));
		end
		$display("test latch done");
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_timing;
		t_modes;
		t_ale;
		end_sim;
	end
endmodule // ext_memory_bus_timing_tb_top
`default_nettype wire
